// *** test/dump_cmd_monitor.sv ***
/* Concurrent checks on the ports of dump_cmd_unit.
 * Assumes one clock, synchronous active-high reset, design header on the include path. */
`timescale 1ns/1ps
`include "dump_cmd_regs.vh"
module dump_cmd_monitor (
	// Clock and reset
	input wire REF_CLK,
	input wire RST,
	// Control and memory master
	input wire [31:0] CU_BASE,
	input wire CNA_ON_SUSPEND,
	input wire MEM_REQ,
	input wire MEM_WE,
	input wire [31:0] MEM_ADDR,
	input wire [31:0] MEM_WDATA,
	input wire MEM_ACK,
	input wire [31:0] MEM_RDATA,
	// Byte streams
	input wire TXF_VALID,
	input wire [7:0] TXF_DATA,
	input wire TXF_READY,
	input wire STF_READY,
	// Status
	input wire BUSY,
	input wire [1:0] UNIT_STATE,
	input wire [31:0] NEXT_CB_ADDR,
	input wire EXEC_INT,
	input wire NOT_ACTIVE_INT
);
	reg [1:0] rd_n_r;
	reg [7:0] wr_n_r;
	reg [7:0] st_n_r;
	reg tx_r;
	reg [31:0] cmd_r;
	reg [31:0] link_r;
	reg [31:0] area_r;
	wire wr = MEM_REQ && MEM_WE;
	wire fin = MEM_ACK && MEM_WE && wr_n_r == 8'd149;
	wire dump = cmd_r[18:16] == `CMD_CODE_DUMP;
	////////////////////////////////////////////////////////////////////////////////
	// Counts restart while idle, so each command is judged on its own
	always @(posedge REF_CLK) begin
		if (RST || !BUSY) begin
			rd_n_r <= 2'd0;
			wr_n_r <= 8'd0;
			st_n_r <= 8'd0;
			tx_r <= 1'b0;
		end else begin
			rd_n_r <= rd_n_r + {1'b0, MEM_ACK && !MEM_WE};
			wr_n_r <= wr_n_r + {7'd0, MEM_ACK && MEM_WE};
			st_n_r <= st_n_r + {7'd0, STF_READY};
			tx_r <= tx_r || (TXF_VALID && TXF_READY);
		end
	end
	// Block words are kept past the end of the command for the closing checks
	always @(posedge REF_CLK) begin
		if (MEM_ACK && !MEM_WE && rd_n_r == 2'd0)
			cmd_r <= MEM_RDATA;
		if (MEM_ACK && !MEM_WE && rd_n_r == 2'd1)
			link_r <= MEM_RDATA;
		if (MEM_ACK && !MEM_WE && rd_n_r == 2'd2)
			area_r <= MEM_RDATA;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking mon_cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	property p_code; wr |-> dump; endproperty
	a_code: assert property (p_code) else $error("write under another code");
	property p_link; $fell(BUSY) && !$past(RST) && dump |-> NEXT_CB_ADDR == link_r + CU_BASE;
	endproperty
	a_link: assert property (p_link) else $error("next block address wrong");
	property p_idle; fin && cmd_r[31] |-> ##[1:2] NOT_ACTIVE_INT && UNIT_STATE == 2'd0; endproperty
	a_idle: assert property (p_idle) else $error("no idle entry");
	property p_susp; fin && cmd_r[30] && !cmd_r[31] |-> ##[1:2] UNIT_STATE == 2'd2; endproperty
	a_susp: assert property (p_susp) else $error("no suspend entry");
	property p_quiet; fin && !cmd_r[31] && !CNA_ON_SUSPEND |-> ##1 !NOT_ACTIVE_INT [*3]; endproperty
	a_quiet: assert property (p_quiet) else $error("unasked not-active pulse");
	property p_exec; fin && cmd_r[29] |-> ##[1:2] EXEC_INT; endproperty
	a_exec: assert property (p_exec) else $error("executed pulse missing");
	property p_noexec; fin && !cmd_r[29] |-> ##1 !EXEC_INT [*3]; endproperty
	a_noexec: assert property (p_noexec) else $error("executed pulse unasked");
	property p_count; $fell(BUSY) && !$past(RST) && dump |-> wr_n_r == 8'd150; endproperty
	a_count: assert property (p_count) else $error("write count wrong");
	property p_txbyte; TXF_VALID |-> TXF_DATA == `DUMP_CMD_BYTE; endproperty
	a_txbyte: assert property (p_txbyte) else $error("wrong command byte");
	property p_wait; wr |-> tx_r; endproperty
	a_wait: assert property (p_wait) else $error("write before command byte");
	property p_order; wr && wr_n_r >= 8'd20 |-> st_n_r >= 8'd81; endproperty
	a_order: assert property (p_order) else $error("parallel before serial");
	property p_addr; wr && wr_n_r < 8'd149 |->
		MEM_ADDR[15:0] == area_r[15:0] + {6'd0, wr_n_r, 2'b00}; endproperty
	a_addr: assert property (p_addr) else $error("dump address out of order");
	property p_status; fin |-> MEM_WDATA[15] && MEM_WDATA[13]; endproperty
	a_status: assert property (p_status) else $error("status flags wrong");
endmodule // dump_cmd_monitor

bind dump_cmd_unit dump_cmd_monitor dump_cmd_monitor_i (.REF_CLK(REF_CLK), .RST(RST),
	.CU_BASE(CU_BASE), .CNA_ON_SUSPEND(CNA_ON_SUSPEND), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
	.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
	.TXF_VALID(TXF_VALID), .TXF_DATA(TXF_DATA), .TXF_READY(TXF_READY), .STF_READY(STF_READY),
	.BUSY(BUSY), .UNIT_STATE(UNIT_STATE), .NEXT_CB_ADDR(NEXT_CB_ADDR), .EXEC_INT(EXEC_INT),
	.NOT_ACTIVE_INT(NOT_ACTIVE_INT));

// *** test/host_side_model.sv ***
/* Far side of the command unit: memory slave, MAC byte streams, parallel registers.
 * Assumes one request at a time and a ready pulse for each status byte taken. */
`timescale 1ns/1ps
`include "dump_cmd_regs.vh"
module host_side_model (
	// Clock and pacing
	input wire clk,
	input wire slow,
	// Memory slave
	input wire req,
	input wire we,
	input wire [31:0] addr,
	input wire [31:0] wdata,
	output reg ack,
	output reg [31:0] rdata,
	// MAC byte streams
	input wire txf_valid,
	output reg txf_ready,
	output wire stf_valid,
	output wire [7:0] stf_data,
	input wire stf_ready,
	// Parallel registers
	input wire [6:0] preg_index,
	output wire [31:0] preg_data
);
	reg [31:0] mem [0:255];
	reg [1:0] wait_r;
	reg [7:0] seq_r;
	initial begin
		ack = 1'b0;
		rdata = 32'h0;
		txf_ready = 1'b0;
		wait_r = 2'd0;
		seq_r = 8'd0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Read data is only good in the ack cycle, so it toggles otherwise
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		txf_ready <= !slow || !txf_ready;
		if (req && !ack && wait_r != {slow, slow})
			wait_r <= wait_r + 2'd1;
		else if (req && !ack) begin
			ack <= 1'b1;
			wait_r <= 2'd0;
			rdata <= mem[addr[9:2]];
			if (we)
				mem[addr[9:2]] <= wdata;
		end
		if (txf_valid && txf_ready)
			seq_r <= 8'd1;
		else if (stf_ready && stf_valid)
			seq_r <= seq_r + 8'd1;
	end
	// One stray byte, the marker, then dump bytes 0..79 valued n+40h
	assign stf_valid = seq_r != 8'd0 && seq_r < 8'd83;
	assign stf_data = seq_r == 8'd2 ? `DUMP_MARKER : seq_r + 8'h3d;
	assign preg_data = {4{1'b1, preg_index}} ^ 32'h0f0f_0f0f;
endmodule // host_side_model

// *** test/tb_top.sv ***
/* Self-checking bench: runs dump commands through the host side model.
 * Assumes the design header is on the include path. */
`timescale 1ns/1ps
module tb_top;
	reg ref_clk, rst, start, cna_on, slow, ex_seen, na_seen, bad_seen;
	reg [31:0] cu_base, cb_addr;
	integer bad_count, checks;
	wire mem_req, mem_we, mem_ack, txf_valid, txf_ready, stf_valid, stf_ready;
	wire busy, exec_int, na_int, bad_cmd;
	wire [31:0] mem_addr, mem_wdata, mem_rdata, preg_data, next_cb;
	wire [7:0] txf_data, stf_data;
	wire [6:0] preg_index;
	wire [1:0] unit_state;
	dump_cmd_unit dump_cmd_unit_i (.REF_CLK(ref_clk), .RST(rst), .START(start),
		.CB_ADDR(cb_addr), .CU_BASE(cu_base), .CNA_ON_SUSPEND(cna_on), .MEM_REQ(mem_req),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack),
		.MEM_RDATA(mem_rdata), .TXF_VALID(txf_valid), .TXF_DATA(txf_data),
		.TXF_READY(txf_ready), .STF_VALID(stf_valid), .STF_DATA(stf_data),
		.STF_READY(stf_ready), .PREG_INDEX(preg_index), .PREG_DATA(preg_data), .BUSY(busy),
		.UNIT_STATE(unit_state), .NEXT_CB_ADDR(next_cb), .EXEC_INT(exec_int),
		.NOT_ACTIVE_INT(na_int), .BAD_CMD(bad_cmd));
	host_side_model host_side_model_i (.clk(ref_clk), .slow(slow), .req(mem_req), .we(mem_we),
		.addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata),
		.txf_valid(txf_valid), .txf_ready(txf_ready), .stf_valid(stf_valid),
		.stf_data(stf_data), .stf_ready(stf_ready), .preg_index(preg_index),
		.preg_data(preg_data));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (exec_int) ex_seen <= 1'b1;
		if (na_int) na_seen <= 1'b1;
		if (bad_cmd) bad_seen <= 1'b1;
	end
	task check(input [31:0] seen, input [31:0] exp, input string what);
	begin
		checks = checks + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task print_verdict;
	begin
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	// Area at 40h, block at cb; the word after the area must stay untouched
	task run(input [31:0] cmd, input [31:0] cb, input c, input s);
		integer n;
		reg [31:0] w;
		reg [7:0] b;
		reg [6:0] idx;
	begin
		cna_on = c;
		slow = s;
		cb_addr = cb;
		host_side_model_i.mem[cb[9:2]] = cmd;
		host_side_model_i.mem[cb[9:2] + 1] = 32'h0000_1230;
		host_side_model_i.mem[cb[9:2] + 2] = 32'h0000_0040;
		for (n = 16; n < 166; n = n + 1)
			host_side_model_i.mem[n] = 32'hdead_beef;
		ex_seen = 1'b0;
		na_seen = 1'b0;
		bad_seen = 1'b0;
		start = 1'b1;
		for (n = 0; n < 4000 && !(n > 8 && !busy); n = n + 1)
			@(negedge ref_clk);
		start = 1'b0;
		check(busy, 0, "busy");
		repeat (4) @(negedge ref_clk);
		w = cmd[18:16] == 3'b110 ? cmd | 32'h0000_a000 : cmd;
		check(host_side_model_i.mem[cb[9:2]], w, "status");
		check(bad_seen, cmd[18:16] != 3'b110, "bad code");
		if (w[15]) begin
			check(ex_seen, cmd[29], "exec");
			check(na_seen, cmd[31] || (cmd[30] && c), "not active");
			check(next_cb, 32'h1230 + cu_base, "next block");
			check(unit_state, cmd[31] ? 0 : 2, "state");
			for (n = 0; n < 150; n = n + 1) begin
				b = n * 4 + 64;
				idx = n - 20;
				w = n < 20 ? {b + 8'd3, b + 8'd2, b + 8'd1, b} : {4{1'b1, idx}} ^ 32'h0f0f_0f0f;
				w = n == 149 ? 32'hdead_beef : w;
				check(host_side_model_i.mem[16 + n], w, "dump word");
			end
		end
	end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		start = 1'b0;
		cna_on = 1'b0;
		slow = 1'b0;
		cb_addr = 32'h0;
		cu_base = 32'h1000_0000;
		bad_count = 0;
		checks = 0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		run(32'ha006_0000, 32'h0, 1'b0, 1'b0);
		run(32'h4006_0000, 32'h320, 1'b0, 1'b1);
		run(32'h4006_0000, 32'h0, 1'b1, 1'b0);
		run(32'h8005_0000, 32'h320, 1'b0, 1'b0);
		// Reset in mid-dump must leave the unit quiet and ready again
		cb_addr = 32'h0;
		host_side_model_i.mem[0] = 32'h8006_0000;
		start = 1'b1;
		repeat (150) @(negedge ref_clk);
		rst = 1'b1;
		start = 1'b0;
		@(negedge ref_clk);
		check(busy, 0, "reset busy");
		check(unit_state, 0, "reset state");
		check(host_side_model_i.mem[0], 32'h8006_0000, "cut status");
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		run(32'ha006_0000, 32'h320, 1'b0, 1'b1);
		print_verdict;
	end
	// Six commands take well under 20000 cycles
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		print_verdict;
	end
endmodule // tb_top

// *** verilog/byte_packer.v ***
/*
 * Packs a byte stream into 32-bit words, first byte in the low lane.
 * Assumes the consumer may stall; a stalled word holds the byte input off.
 */
`timescale 1ns/1ps
module byte_packer (
	input wire clk,
	input wire rst,
	// Byte side
	input wire byte_valid,
	output wire byte_ready,
	input wire [7:0] byte_data,
	// Word side
	output reg word_valid,
	input wire word_ready,
	output reg [31:0] word_data
);
	reg [1:0] lane_r;
	reg [23:0] acc_r;

	assign byte_ready = !word_valid || word_ready;

	always @(posedge clk) begin
		if (rst) begin
			lane_r <= 2'h0;
			acc_r <= 24'h000000;
			word_valid <= 1'b0;
			word_data <= 32'h00000000;
		end else begin
			if (word_valid && word_ready) begin
				word_valid <= 1'b0;
			end
			if (byte_valid && byte_ready) begin
				lane_r <= lane_r + 2'h1;
				if (lane_r == 2'h3) begin
					word_data <= {byte_data, acc_r};
					word_valid <= 1'b1;
				end else if (lane_r == 2'h0) begin
					acc_r <= {16'h0000, byte_data};
				end else if (lane_r == 2'h1) begin
					acc_r <= {8'h00, byte_data, acc_r[7:0]};
				end else begin
					acc_r <= {byte_data, acc_r[15:0]};
				end
			end
		end
	end
endmodule // byte_packer

// *** verilog/dump_cmd_regs.vh ***
/*
 * Constants of the register dump action command: command block layout,
 * command word fields, dump area layout and sequencing counts.
 * Assumes it is included by bare name from each design file that needs it.
 */
// Notes on behaviour
// RULE1: A block whose command field in bits 18:16 of the first word is 110 is a dump command.
// RULE2: The word at block offset 04h is the next block pointer and is added to the unit base.
// RULE3: With the end-of-list flag in bit 31 set the unit goes idle and always raises not-active.
// RULE4: With the suspend flag in bit 30 set the unit suspends and raises not-active only if enabled.
// RULE5: With the interrupt flag in bit 29 set the executed interrupt is raised, otherwise never.
// RULE6: Software writes zero to reserved bits 28:19 of the command word.
// RULE7: Software clears the completion flag in bit 15 and the device sets it when finished.
// RULE8: Success is the flag in bit 13; completion with success clear means an error.
// RULE9: The word at block offset 08h is the dump area offset and the area is 596 bytes long.
// RULE10: The unit posts the dump command byte to the transmit FIFO and waits for the marker.
// RULE11: The frame extraction and MAC state comes through the status FIFO before parallel state.
// RULE12: After all data the status word is built with completion and success both 1.
// RULE13: Bytes 0 to 23 hold the pointer, counter and threshold registers, low byte first.
// RULE14: Bytes 24 to 37 hold configuration bytes 8 to 21, byte 38 reserved, 39 to 42 address 1-4.
// RULE15: The rest of the area follows the byte table and the dword table.
// RULE16: After address bytes 5 and 6, byte 45 on holds status, CRC, temp, hash and length.
// RULE17: Dump words are written at rising addresses from the area start, completion last.
`ifndef DUMP_CMD_REGS_VH
`define DUMP_CMD_REGS_VH

`define CB_OFS_CMD 32'h00000000
`define CB_OFS_LINK 32'h00000004
`define CB_OFS_BUF 32'h00000008

`define CMD_EOL_BIT 31
`define CMD_SUSP_BIT 30
`define CMD_INT_BIT 29
`define CMD_CODE_HI 18
`define CMD_CODE_LO 16
`define CMD_DONE_BIT 15
`define CMD_OK_BIT 13
`define CMD_CODE_DUMP 3'h6

`define DUMP_AREA_BYTES 596
`define DUMP_AREA_WORDS 9'h095
`define DUMP_FIFO_BYTES 8'h50
`define DUMP_CMD_BYTE 8'h06
`define DUMP_MARKER 8'ha5
`define FIFO_WIDTH 32
`define FIFO_DEPTH 16
`define FIFO_ADDR_W 4

`endif

// *** verilog/dump_cmd_unit.v ***
/*
 * Command unit slice that executes the register dump action command:
 * fetches the command block, runs the dump sequence, writes the area
 * and posts status. Assumes a simple memory master port that answers
 * each request with one ack, a status FIFO stream from the MAC side,
 * and a parallel-register read port answering one cycle after address.
 */
`timescale 1ns/1ps
`include "dump_cmd_regs.vh"
module dump_cmd_unit (
	// Clock and reset
	input wire REF_CLK,
	input wire RST,
	// Control
	input wire START,
	input wire [31:0] CB_ADDR,
	input wire [31:0] CU_BASE,
	input wire CNA_ON_SUSPEND,
	// Memory master
	output reg MEM_REQ,
	output reg MEM_WE,
	output reg [31:0] MEM_ADDR,
	output reg [31:0] MEM_WDATA,
	input wire MEM_ACK,
	input wire [31:0] MEM_RDATA,
	// Transmit FIFO towards MAC
	output reg TXF_VALID,
	output reg [7:0] TXF_DATA,
	input wire TXF_READY,
	// Status FIFO from MAC
	input wire STF_VALID,
	input wire [7:0] STF_DATA,
	output reg STF_READY,
	// Parallel register read port
	output reg [6:0] PREG_INDEX,
	input wire [31:0] PREG_DATA,
	// Status
	output reg BUSY,
	output reg [1:0] UNIT_STATE,
	output reg [31:0] NEXT_CB_ADDR,
	output reg EXEC_INT,
	output reg NOT_ACTIVE_INT,
	output reg BAD_CMD
);
	localparam S_IDLE = 4'h0;
	localparam S_FETCH0 = 4'h1;
	localparam S_FETCH1 = 4'h2;
	localparam S_FETCH2 = 4'h3;
	localparam S_TXCMD = 4'h4;
	localparam S_MARK = 4'h5;
	localparam S_SERIAL = 4'h6;
	localparam S_PREQ = 4'h7;
	localparam S_PCAP = 4'h8;
	localparam S_DRAIN = 4'h9;
	localparam S_STATUS = 4'ha;
	localparam S_DONE = 4'hb;
	localparam U_IDLE = 2'h0;
	localparam U_ACTIVE = 2'h1;
	localparam U_SUSP = 2'h2;

	reg [3:0] st_r;
	reg [31:0] cmd_r;
	reg [31:0] cb_r;
	reg [31:0] area_r;
	reg [7:0] scnt_r;
	reg [8:0] wcnt_r;
	reg [7:0] pidx_r;
	reg start_q1_r;
	reg start_q2_r;
	reg start_q3_r;
	reg stf_v1_r;
	reg stf_v2_r;
	reg [7:0] stf_d1_r;
	reg [7:0] stf_d2_r;
	reg [1:0] stf_hold_r;

	// Packer and FIFO interconnect
	reg pk_in_valid;
	reg [7:0] pk_in_data;
	wire pk_in_ready;
	wire pk_word_valid;
	wire pk_word_ready;
	wire [31:0] pk_word_data;
	reg par_valid;
	wire f_in_valid;
	wire [31:0] f_in_data;
	wire f_in_ready;
	wire f_out_valid;
	wire [31:0] f_out_data;
	reg f_out_ready;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers for the start strobe and the status FIFO stream

	always @(posedge REF_CLK) begin
		if (RST) begin
			start_q1_r <= 1'b0;
			start_q2_r <= 1'b0;
			start_q3_r <= 1'b0;
			stf_v1_r <= 1'b0;
			stf_v2_r <= 1'b0;
			stf_d1_r <= 8'h00;
			stf_d2_r <= 8'h00;
		end else begin
			start_q1_r <= START;
			start_q2_r <= start_q1_r;
			start_q3_r <= start_q2_r;
			stf_v1_r <= STF_VALID;
			stf_v2_r <= stf_v1_r;
			stf_d1_r <= STF_DATA;
			stf_d2_r <= stf_d1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data path: serial bytes packed, parallel words direct, one FIFO

	byte_packer u_packer (
		.clk(REF_CLK),
		.rst(RST),
		.byte_valid(pk_in_valid),
		.byte_ready(pk_in_ready),
		.byte_data(pk_in_data),
		.word_valid(pk_word_valid),
		.word_ready(pk_word_ready),
		.word_data(pk_word_data)
	);

	// Serial words own the FIFO input until the parallel phase starts
	assign f_in_valid = pk_word_valid | par_valid; // RULE11
	assign f_in_data = par_valid ? PREG_DATA : pk_word_data;
	assign pk_word_ready = f_in_ready & !par_valid;

	dump_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_ADDR_W)
	) u_fifo (
		.clk(REF_CLK),
		.rst(RST),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(f_in_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// The source moves on one cycle after ready and the new byte needs two
	// more to cross, so takes are held off three cycles to avoid repeats.
	always @* begin
		pk_in_valid = 1'b0;
		pk_in_data = stf_d2_r;
		par_valid = 1'b0;
		if (st_r == S_SERIAL && stf_v2_r && !STF_READY && stf_hold_r == 2'h0 &&
			scnt_r != `DUMP_FIFO_BYTES) begin
			pk_in_valid = 1'b1; // RULE13 RULE14 RULE16
		end
		if (st_r == S_PCAP) begin
			par_valid = 1'b1; // RULE15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always @(posedge REF_CLK) begin
		if (RST) begin
			st_r <= S_IDLE;
			cmd_r <= 32'h00000000;
			cb_r <= 32'h00000000;
			area_r <= 32'h00000000;
			scnt_r <= 8'h00;
			wcnt_r <= 9'h000;
			pidx_r <= 8'h00;
			stf_hold_r <= 2'h0;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 32'h00000000;
			MEM_WDATA <= 32'h00000000;
			TXF_VALID <= 1'b0;
			TXF_DATA <= 8'h00;
			STF_READY <= 1'b0;
			PREG_INDEX <= 7'h00;
			BUSY <= 1'b0;
			UNIT_STATE <= U_IDLE;
			NEXT_CB_ADDR <= 32'h00000000;
			EXEC_INT <= 1'b0;
			NOT_ACTIVE_INT <= 1'b0;
			BAD_CMD <= 1'b0;
			f_out_ready <= 1'b0;
		end else begin
			EXEC_INT <= 1'b0;
			NOT_ACTIVE_INT <= 1'b0;
			BAD_CMD <= 1'b0;
			STF_READY <= 1'b0;
			f_out_ready <= 1'b0;
			if (stf_hold_r != 2'h0) begin
				stf_hold_r <= stf_hold_r - 2'h1;
			end
			case (st_r)
			S_IDLE: begin
				if (start_q2_r && !start_q3_r) begin
					cb_r <= CB_ADDR;
					BUSY <= 1'b1;
					UNIT_STATE <= U_ACTIVE;
					MEM_REQ <= 1'b1;
					MEM_WE <= 1'b0;
					MEM_ADDR <= CB_ADDR + `CB_OFS_CMD;
					st_r <= S_FETCH0;
				end
			end
			S_FETCH0: begin
				if (MEM_ACK) begin
					MEM_REQ <= 1'b0;
					cmd_r <= MEM_RDATA;
					if (MEM_RDATA[`CMD_CODE_HI:`CMD_CODE_LO] == `CMD_CODE_DUMP) begin
						MEM_REQ <= 1'b1; // RULE1
						MEM_ADDR <= cb_r + `CB_OFS_LINK;
						st_r <= S_FETCH1;
					end else begin
						// Other commands belong to other slices of the unit
						BAD_CMD <= 1'b1;
						BUSY <= 1'b0;
						UNIT_STATE <= U_IDLE;
						st_r <= S_IDLE;
					end
				end
			end
			S_FETCH1: begin
				if (MEM_ACK) begin
					NEXT_CB_ADDR <= MEM_RDATA + CU_BASE; // RULE2
					MEM_ADDR <= cb_r + `CB_OFS_BUF;
					st_r <= S_FETCH2;
				end
			end
			S_FETCH2: begin
				if (MEM_ACK) begin
					MEM_REQ <= 1'b0;
					area_r <= MEM_RDATA; // RULE9
					TXF_VALID <= 1'b1;
					TXF_DATA <= `DUMP_CMD_BYTE; // RULE10
					st_r <= S_TXCMD;
				end
			end
			S_TXCMD: begin
				if (TXF_READY) begin
					TXF_VALID <= 1'b0;
					st_r <= S_MARK;
				end
			end
			S_MARK: begin
				// Anything ahead of the marker is stale and thrown away
				if (stf_v2_r && !STF_READY && stf_hold_r == 2'h0) begin
					STF_READY <= 1'b1;
					stf_hold_r <= 2'h3;
					if (stf_d2_r == `DUMP_MARKER) begin
						scnt_r <= 8'h00; // RULE10
						wcnt_r <= 9'h000;
						st_r <= S_SERIAL;
					end
				end
			end
			S_SERIAL: begin
				if (pk_in_valid && pk_in_ready) begin
					STF_READY <= 1'b1;
					stf_hold_r <= 2'h3;
					scnt_r <= scnt_r + 8'h01;
				end
				if (scnt_r == `DUMP_FIFO_BYTES && !pk_word_valid) begin
					pidx_r <= 8'h00; // RULE11
					PREG_INDEX <= 7'h00;
					st_r <= S_PREQ;
				end
			end
			S_PREQ: begin
				st_r <= S_PCAP;
			end
			S_PCAP: begin
				// Index port is 7 bits wide, so the 129th word reads index 0 again
				if (f_in_ready) begin
					pidx_r <= pidx_r + 8'h01;
					PREG_INDEX <= pidx_r[6:0] + 7'h01;
					if ({1'b0, pidx_r} + 9'h014 == `DUMP_AREA_WORDS - 9'h001) begin
						st_r <= S_DRAIN;
					end else begin
						st_r <= S_PREQ;
					end
				end
			end
			S_DRAIN: begin
				if (wcnt_r == `DUMP_AREA_WORDS && !f_out_valid && !MEM_REQ) begin
					MEM_REQ <= 1'b1;
					MEM_WE <= 1'b1;
					MEM_ADDR <= cb_r + `CB_OFS_CMD;
					MEM_WDATA <= cmd_r | (32'h1 << `CMD_DONE_BIT) | (32'h1 << `CMD_OK_BIT);
					st_r <= S_STATUS; // RULE12 RULE17
				end
			end
			S_STATUS: begin
				if (MEM_ACK) begin
					MEM_REQ <= 1'b0;
					MEM_WE <= 1'b0;
					st_r <= S_DONE; // RULE7 RULE8
				end
			end
			S_DONE: begin
				BUSY <= 1'b0;
				EXEC_INT <= cmd_r[`CMD_INT_BIT]; // RULE5
				if (cmd_r[`CMD_EOL_BIT]) begin
					UNIT_STATE <= U_IDLE;
					NOT_ACTIVE_INT <= 1'b1; // RULE3
				end else if (cmd_r[`CMD_SUSP_BIT]) begin
					UNIT_STATE <= U_SUSP;
					NOT_ACTIVE_INT <= CNA_ON_SUSPEND; // RULE4
				end else begin
					UNIT_STATE <= U_ACTIVE;
				end
				st_r <= S_IDLE;
			end
			default: begin
				st_r <= S_IDLE;
			end
			endcase

			// Dump area writer runs beside the producers during the dump
			if ((st_r == S_SERIAL || st_r == S_PREQ || st_r == S_PCAP || st_r == S_DRAIN)) begin
				if (MEM_REQ && MEM_WE && MEM_ACK) begin
					MEM_REQ <= 1'b0;
					MEM_WE <= 1'b0;
				end else if (!MEM_REQ && f_out_valid && !f_out_ready) begin
					MEM_REQ <= 1'b1;
					MEM_WE <= 1'b1;
					MEM_ADDR <= area_r + {21'h000000, wcnt_r, 2'h0}; // RULE17
					MEM_WDATA <= f_out_data;
					f_out_ready <= 1'b1;
					wcnt_r <= wcnt_r + 9'h001;
				end
			end
		end
	end
endmodule // dump_cmd_unit

// *** verilog/dump_fifo.v ***
/*
 * Synchronous FIFO of parameterised width and depth with valid and ready
 * on both sides. Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module dump_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // dump_fifo
